// File: phy_link_mode_control_test.sv
// self-checking testbench for the link mode control block
`timescale 1ns/10ps
module phy_link_mode_control_test import plm_pkg::*;;
	localparam int BRK = 20;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] awaddr = 8'h00;
	logic [7:0] araddr = 8'h00;
	logic [31:0] wdata = 32'h00000000;
	logic [3:0] wstrb = 4'hf;
	logic awvalid = 1'b0;
	logic wvalid = 1'b0;
	logic bready = 1'b0;
	logic arvalid = 1'b0;
	logic rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp;
	logic [1:0] rresp;
	logic [31:0] rdata;
	logic [2:0] kind = 3'h0;
	logic [15:0] word = 16'h0000;
	logic tx = 1'b0;
	logic rx = 1'b0;
	plm_line_t line_sig;
	plm_mode_t mode;
	int errors = 0;
	int cmp_count = 0;
	// partner word, expected speed100 and full duplex
	logic [17:0] flp_tab [4] = '{{16'h01e1, 2'b11}, {16'h00a1, 2'b10}, {16'h0061, 2'b01}, {16'h0021, 2'b00}};

	// 100 MHz clock
	always #5 clk = ~clk;

	plm_link_ctrl #(.BREAK_CYC(BRK)) u_dut (.clk(clk), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .line_in(line_sig), .mode_out(mode));

	plm_partner_model u_partner (.clk(clk), .rst(rst), .kind(kind), .word(word), .tx(tx), .rx(rx),
		.mode(mode), .line_sig(line_sig));

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask : cyc

	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		cmp_count++;
		if (g !== e) begin
			errors++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	// one write: address and data offered together, each released when taken
	task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] er);
		awaddr <= a;
		wdata <= {16'h0000, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid);
		bready <= 1'b0;
		chk("bresp", {14'h0000, er}, {14'h0000, bresp});
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [15:0] e, input logic [1:0] er, input string nm);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clk);
			if (arready) arvalid <= 1'b0;
		end while (!rvalid);
		rready <= 1'b0;
		chk(nm, e, rdata[15:0]);
		chk("rresp", {14'h0000, er}, {14'h0000, rresp});
	endtask : rd

	task automatic mchk(input logic l, input logic s, input logic f, input logic h);
		chk("mode", {12'h000, l, s, f, h}, {12'h000, mode.link_up, mode.speed100, mode.full_duplex, mode.halt});
	endtask : mchk

	// all four transmit and receive combinations against carrier and collision
	task automatic act_chk(input logic fd);
		for (int i = 0; i < 4; i++) begin
			tx <= i[1];
			rx <= i[0];
			cyc(3);
			chk("crs_col", {14'h0000, i[0] | (!fd & i[1]), !fd & i[1] & i[0]}, {14'h0000, mode.crs, mode.col});
		end
		tx <= 1'b0;
		rx <= 1'b0;
	endtask : act_chk

	task automatic do_reset;
		rst <= 1'b1;
		cyc(2);
		rst <= 1'b0;
		cyc(1);
	endtask : do_reset

	task automatic summarize;
		$display("errors %0d comparisons %0d", errors, cmp_count);
		if (errors == 0 && cmp_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : summarize

	// watchdog against a hung handshake
	initial begin
		cyc(20000);
		errors++;
		summarize();
	end

	// main sequence
	initial begin
		do_reset();
		rd(8'h00, 16'h3100, RESP_OKAY, "ctrl_rst");
		rd(8'h10, 16'h01e1, RESP_OKAY, "adv_rst");
		rd(8'h18, 16'h0000, RESP_OKAY, "anx_rst");
		rd(8'h0c, 16'h0000, RESP_SLVERR, "unmapped");
		wr(8'h24, 16'h1234, RESP_SLVERR);
		wr(8'h14, 16'hffff, RESP_OKAY);
		rd(8'h14, 16'h0000, RESP_OKAY, "lpa_ro");
		// negotiated links, each followed by signal loss
		for (int i = 0; i < 4; i++) begin
			word <= flp_tab[i][17:2];
			kind <= 3'h1;
			cyc(4);
			mchk(1'b1, flp_tab[i][1], flp_tab[i][0], 1'b0);
			rd(8'h14, flp_tab[i][17:2], RESP_OKAY, "lpa_flp");
			rd(8'h18, 16'h0001, RESP_OKAY, "anx_flp");
			kind <= 3'h0;
			cyc(4);
			// speed and duplex keep the last resolved mode while negotiating again
			rd(8'h20, {10'h000, 2'b10, 1'b0, flp_tab[i][0], flp_tab[i][1], 1'b0}, RESP_OKAY, "stat_lost");
			chk("flp_tx_neg", 16'h0001, {15'h0000, mode.flp_tx_en});
		end
		// parallel detect at 100M, traffic, ability write and restart
		kind <= 3'h2;
		cyc(4);
		mchk(1'b1, 1'b1, 1'b0, 1'b0);
		rd(8'h14, 16'h0081, RESP_OKAY, "lpa_pd100");
		rd(8'h18, 16'h0000, RESP_OKAY, "anx_pd");
		act_chk(1'b0);
		wr(8'h10, 16'h0020, RESP_OKAY);
		chk("adv_word", 16'h0021, mode.adv_word);
		rd(8'h20, 16'h0033, RESP_OKAY, "stat_adv");
		wr(8'h00, 16'h3300, RESP_OKAY);
		cyc(2);
		chk("brk_start", 16'h0001, {13'h0000, mode.flp_tx_en, mode.link_up, mode.halt});
		rd(8'h00, 16'h3100, RESP_OKAY, "ctrl_sc");
		cyc(BRK - 10);
		chk("brk_hold", 16'h0001, {13'h0000, mode.flp_tx_en, mode.link_up, mode.halt});
		cyc(10);
		chk("brk_end", 16'h0002, {14'h0000, mode.link_up, mode.halt});
		kind <= 3'h0;
		cyc(4);
		// parallel detect at 10M
		kind <= 3'h3;
		cyc(4);
		mchk(1'b1, 1'b0, 1'b0, 1'b0);
		rd(8'h14, 16'h0021, RESP_OKAY, "lpa_pd10");
		kind <= 3'h0;
		cyc(4);
		// detection fault, latched until read
		kind <= 3'h4;
		cyc(4);
		kind <= 3'h0;
		cyc(2);
		rd(8'h18, 16'h0010, RESP_OKAY, "anx_fault");
		rd(8'h18, 16'h0000, RESP_OKAY, "anx_clr");
		// second reset, full duplex link, then forced modes
		do_reset();
		word <= 16'h01e1;
		kind <= 3'h1;
		cyc(4);
		mchk(1'b1, 1'b1, 1'b1, 1'b0);
		act_chk(1'b1);
		wr(8'h00, 16'h1000, RESP_OKAY);
		rd(8'h20, 16'h0037, RESP_OKAY, "stat_an");
		wr(8'h00, 16'h0000, RESP_OKAY);
		cyc(1); // forced speed and duplex land one edge after the state change
		rd(8'h20, 16'h0001, RESP_OKAY, "stat_10h");
		wr(8'h00, 16'h2100, RESP_OKAY);
		rd(8'h20, 16'h0007, RESP_OKAY, "stat_100f");
		summarize();
	end
endmodule : phy_link_mode_control_test

// File: plm_link_ctrl.sv
// link mode control: negotiation, parallel detect, forced mode, crs and col
`timescale 1ns/10ps
module plm_link_ctrl import plm_pkg::*; #(
	parameter int BREAK_CYC = BREAK_LINK_CYC
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// axi4-lite slave
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// datapath indications, same clock
	input wire plm_line_t line_in,
	// resolved mode
	output plm_mode_t mode_out
);

	localparam logic [BRK_W-1:0] BRK_LAST = BRK_W'(BREAK_CYC - 1);

	plm_st_t s;
	plm_st_t n;
	logic an_en;
	logic wr_fire;
	logic rd_fire;
	logic [15:0] wmask;
	logic [3:0] common;
	logic [5:0] rd_idx;
	logic [5:0] wr_idx;

	// next state of bus slave and link control
	always_comb begin
		n = s;
		an_en = s.r.ctrl[CTRL_AN_EN_BIT];
		wr_fire = s.b.aw_got && s.b.w_got && !s.b.bvalid;
		rd_fire = s_axi_arvalid && s.b.arready;
		wmask = {{8{s.b.wstrb[1]}}, {8{s.b.wstrb[0]}}};
		common = s.r.adv[ABIL_100FD:ABIL_10HD] & line_in.flp_word[ABIL_100FD:ABIL_10HD];
		rd_idx = s_axi_araddr[7:2];
		wr_idx = s.b.awaddr[7:2];

		// address and data taken in either order
		if (s_axi_awvalid && s.b.awready) begin
			n.b.aw_got = 1'b1;
			n.b.awaddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s.b.wready) begin
			n.b.w_got = 1'b1;
			n.b.wdata = s_axi_wdata[15:0];
			n.b.wstrb = s_axi_wstrb[1:0];
		end
		if (s.b.bvalid && s_axi_bready) begin
			n.b.bvalid = 1'b0;
		end

		// read channel, fault flag clears when its register is read
		if (s.b.rvalid && s_axi_rready) begin
			n.b.rvalid = 1'b0;
		end
		if (rd_fire) begin
			n.b.rvalid = 1'b1;
			n.b.rresp = RESP_OKAY;
			n.b.rdata = 32'h0000_0000;
			if (s_axi_araddr[1:0] != 2'b00) begin
				n.b.rresp = RESP_SLVERR;
			end else if (rd_idx == IDX_CTRL) begin
				n.b.rdata[15:0] = s.r.ctrl;
			end else if (rd_idx == IDX_ADV) begin
				n.b.rdata[15:0] = s.r.adv;
			end else if (rd_idx == IDX_LPA) begin
				n.b.rdata[15:0] = s.r.lpa;
			end else if (rd_idx == IDX_ANX) begin
				n.b.rdata[ANX_LP_AN_BIT] = s.r.lp_an;
				n.b.rdata[ANX_PD_FAULT_BIT] = s.r.pd_fault;
				n.r.pd_fault = 1'b0;
			end else if (rd_idx == IDX_STAT) begin
				n.b.rdata[STAT_LINK_BIT] = s.r.link;
				n.b.rdata[STAT_SPEED_BIT] = s.r.speed100;
				n.b.rdata[STAT_FD_BIT] = s.r.fd;
				n.b.rdata[STAT_HALT_BIT] = s.r.halt;
				n.b.rdata[STAT_STATE_LSB+1:STAT_STATE_LSB] = s.r.state;
			end else begin
				n.b.rresp = RESP_SLVERR;
			end
		end

		// negotiation state machine
		unique case (s.r.state)
			ST_FORCED: begin
				n.r.speed100 = s.r.ctrl[CTRL_SPEED_BIT]; // R10
				n.r.fd = s.r.ctrl[CTRL_DUPLEX_BIT]; // R10
				if (an_en) begin
					n.r.state = ST_NEG;
				end
			end
			ST_BREAK: begin
				n.r.brk_cnt = s.r.brk_cnt + 1'b1;
				if (!an_en) begin
					n.r.state = ST_FORCED; // R9
				end else if (s.r.brk_cnt == BRK_LAST) begin
					n.r.state = ST_NEG; // R8
					n.r.brk_cnt = '0;
				end
			end
			ST_NEG: begin
				if (!an_en) begin
					n.r.state = ST_FORCED; // R9
				end else if (line_in.flp_valid) begin
					n.r.lpa = line_in.flp_word; // R4
					n.r.lp_an = 1'b1;
					if (|common) begin
						// highest common mode wins, forced bits unused
						n.r.speed100 = common[3] | common[2]; // R19 R11
						n.r.fd = common[3] | (!common[2] & common[1]); // R19 R11
						n.r.state = ST_LINK;
					end
				end else if (line_in.mlt3_det ^ line_in.nlp_det) begin
					n.r.speed100 = line_in.mlt3_det; // R1
					n.r.fd = 1'b0; // R1
					n.r.lp_an = 1'b0; // R2
					n.r.lpa = SEL_8023;
					n.r.lpa[ABIL_100HD] = line_in.mlt3_det; // R5
					n.r.lpa[ABIL_10HD] = line_in.nlp_det; // R5
					n.r.state = ST_LINK;
				end
				// fault sets over a clearing read in the same cycle
				if (an_en && !line_in.flp_valid && (line_in.pd_fault || (line_in.mlt3_det && line_in.nlp_det))) begin
					n.r.pd_fault = 1'b1; // R3
				end
			end
			ST_LINK: begin
				if (!an_en) begin
					n.r.state = ST_FORCED; // R9
				end else if (!line_in.sig_det) begin
					n.r.state = ST_NEG; // R7
				end
			end
		endcase

		// restart request enters break-link wait and self-clears
		if (an_en && s.r.ctrl[CTRL_RESTART_BIT] && s.r.state != ST_BREAK) begin
			n.r.state = ST_BREAK; // R6 R8
			n.r.brk_cnt = '0;
			n.r.ctrl[CTRL_RESTART_BIT] = 1'b0; // R20
		end

		// register writes land after the self-clear so a new request wins
		if (wr_fire) begin
			n.b.aw_got = 1'b0;
			n.b.w_got = 1'b0;
			n.b.bvalid = 1'b1;
			n.b.bresp = RESP_OKAY;
			if (s.b.awaddr[1:0] != 2'b00) begin
				n.b.bresp = RESP_SLVERR;
			end else if (wr_idx == IDX_CTRL) begin
				n.r.ctrl = (n.r.ctrl & ~(CTRL_WR_MASK & wmask)) | (s.b.wdata & CTRL_WR_MASK & wmask); // R6 R9
			end else if (wr_idx == IDX_ADV) begin
				n.r.adv = (s.r.adv & ~(ADV_WR_MASK & wmask)) | (s.b.wdata & ADV_WR_MASK & wmask); // R18
			end else if (wr_idx != IDX_LPA && wr_idx != IDX_ANX && wr_idx != IDX_STAT) begin
				n.b.bresp = RESP_SLVERR;
			end
		end

		// mode outputs follow the next state
		n.r.halt = (n.r.state == ST_BREAK); // R8
		n.r.flp_tx = (n.r.state == ST_NEG);
		n.r.link = (n.r.state == ST_LINK) || (n.r.state == ST_FORCED && line_in.sig_det);

		// carrier and collision from current mode
		n.r.crs = s.r.link && !s.r.halt && (line_in.rx_act || (!s.r.fd && line_in.tx_act)); // R12 R14 R16 R17
		n.r.col = s.r.link && !s.r.halt && !s.r.fd && line_in.tx_act && line_in.rx_act; // R13 R15

		n.b.awready = !n.b.aw_got && !n.b.bvalid;
		n.b.wready = !n.b.w_got && !n.b.bvalid;
		n.b.arready = !n.b.rvalid;
	end

	// single state register
	always_ff @(posedge clk) begin
		if (rst) begin
			s <= ST_RESET;
		end else begin
			s <= n;
		end
	end

	// outputs straight from the state register
	assign s_axi_awready = s.b.awready;
	assign s_axi_wready = s.b.wready;
	assign s_axi_bvalid = s.b.bvalid;
	assign s_axi_bresp = s.b.bresp;
	assign s_axi_arready = s.b.arready;
	assign s_axi_rvalid = s.b.rvalid;
	assign s_axi_rresp = s.b.rresp;
	assign s_axi_rdata = s.b.rdata;
	assign mode_out.link_up = s.r.link;
	assign mode_out.speed100 = s.r.speed100;
	assign mode_out.full_duplex = s.r.fd;
	assign mode_out.crs = s.r.crs;
	assign mode_out.col = s.r.col;
	assign mode_out.halt = s.r.halt;
	assign mode_out.flp_tx_en = s.r.flp_tx;
	assign mode_out.adv_word = s.r.adv;

	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	sequence restart_seen;
		s.r.ctrl[CTRL_AN_EN_BIT] && s.r.ctrl[CTRL_RESTART_BIT] && s.r.state != ST_BREAK;
	endsequence

	sequence break_entered;
		s.r.state == ST_BREAK && s.r.halt && !s.r.ctrl[CTRL_RESTART_BIT] && s.r.brk_cnt == '0;
	endsequence

	restart_break_a: assert property (restart_seen |=> break_entered) // R8
		else $error("restart did not enter break wait");
	restart_clear_a: assert property (restart_seen ##1 s.r.state == ST_BREAK |-> ##1 s.r.state == ST_BREAK) // R20
		else $error("break wait left too early");
	break_done_a: assert property ((s.r.state == ST_BREAK && s.r.brk_cnt == BRK_LAST && an_en && !s.r.ctrl[CTRL_RESTART_BIT])
		|=> s.r.state == ST_NEG && !s.r.halt && s.r.flp_tx) // R8
		else $error("break wait did not end in negotiation");
	link_loss_a: assert property ((s.r.state == ST_LINK && an_en && !s.r.ctrl[CTRL_RESTART_BIT] && !line_in.sig_det)
		|=> s.r.state == ST_NEG && !s.r.link) // R7
		else $error("signal loss did not restart");
	pd_half_a: assert property ((s.r.state == ST_NEG && an_en && !s.r.ctrl[CTRL_RESTART_BIT] && !line_in.flp_valid
		&& (line_in.mlt3_det ^ line_in.nlp_det)) |=> s.r.link && !s.r.fd && !s.r.lp_an
		&& s.r.speed100 == $past(line_in.mlt3_det) && s.r.lpa[ABIL_100HD] == $past(line_in.mlt3_det)) // R1 R2 R5
		else $error("parallel detect mode wrong");
	pd_fault_a: assert property ((s.r.state == ST_NEG && an_en && !line_in.flp_valid && line_in.pd_fault)
		|=> s.r.pd_fault) // R3
		else $error("parallel detect fault not flagged");
	lp_store_a: assert property ((s.r.state == ST_NEG && an_en && line_in.flp_valid)
		|=> s.r.lpa == $past(line_in.flp_word) && s.r.lp_an) // R4
		else $error("partner ability not stored");
	resolve_best_a: assert property ((s.r.state == ST_NEG && an_en && !s.r.ctrl[CTRL_RESTART_BIT] && line_in.flp_valid
		&& common[3]) |=> s.r.speed100 && s.r.fd && s.r.state == ST_LINK) // R19 R11
		else $error("best common mode not chosen");
	forced_mode_a: assert property ((s.r.state == ST_FORCED) |=> s.r.speed100 == $past(s.r.ctrl[CTRL_SPEED_BIT])
		&& s.r.fd == $past(s.r.ctrl[CTRL_DUPLEX_BIT])) // R10
		else $error("forced mode not applied");
	an_off_a: assert property ((!an_en && !wr_fire) |=> ##1 s.r.state == ST_FORCED && !s.r.flp_tx) // R9
		else $error("negotiation not stopped");
	half_col_a: assert property ((s.r.link && !s.r.halt && !s.r.fd && line_in.tx_act && line_in.rx_act)
		|=> s.r.col && s.r.crs) // R12 R13
		else $error("half duplex collision missed");
	full_crs_a: assert property ((s.r.fd && line_in.tx_act && !line_in.rx_act) |=> !s.r.crs && !s.r.col) // R14 R15 R17
		else $error("full duplex carrier or collision on transmit");
	rx_crs_a: assert property ((s.r.link && !s.r.halt && line_in.rx_act) |=> s.r.crs) // R16
		else $error("carrier not raised on receive");

endmodule : plm_link_ctrl

// File: plm_partner_model.sv
// remote link partner model feeding the datapath indications
`timescale 1ns/10ps
module plm_partner_model import plm_pkg::*; (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// scenario: 0 silent, 1 flp, 2 mlt3, 3 nlp, 4 fault
	input wire logic [2:0] kind,
	input wire logic [15:0] word,
	input wire logic tx,
	input wire logic rx,
	// device side
	input wire plm_mode_t mode,
	output plm_line_t line_sig
);
	plm_line_t line_reg = '0;
	logic sent_reg = 1'b0;
	assign line_sig = line_reg;
	// one code word per burst episode; the partner loses signal while the device halts
	always @(posedge clk) begin
		sent_reg <= !rst && kind == 3'h1 && (sent_reg || mode.flp_tx_en);
		line_reg.flp_valid <= !rst && kind == 3'h1 && !sent_reg && mode.flp_tx_en;
		line_reg.flp_word <= (kind == 3'h1) ? word : ~line_reg.flp_word; // word only valid with pulse
		line_reg.mlt3_det <= kind == 3'h2 && !mode.halt;
		line_reg.nlp_det <= kind == 3'h3 && !mode.halt;
		line_reg.pd_fault <= kind == 3'h4;
		line_reg.sig_det <= kind != 3'h0 && !mode.halt;
		line_reg.tx_act <= tx;
		line_reg.rx_act <= rx && kind != 3'h0 && !mode.halt;
	end
endmodule : plm_partner_model

// File: plm_pkg.sv
// constants, types and reset values for the phy link mode control block
// Summary of operation
// R1 - no FLPs: speed from symbols, half duplex
// R2 - parallel detect link clears partner-capable flag
// R3 - fault during parallel detect sets fault flag
// R4 - store partner ability word from FLPs
// R5 - parallel detect updates partner ability register
// R6 - restart bit write starts new negotiation
// R7 - signal loss restarts negotiation automatically
// R8 - restart halts traffic, waits break-link timer
// R9 - clearing enable bit stops negotiation
// R10 - disabled: force speed and duplex bits
// R11 - enabled: forced speed and duplex ignored
// R12 - half duplex: carrier follows tx and rx
// R13 - half duplex: rx during tx is collision
// R14 - full duplex: carrier follows receive only
// R15 - full duplex: collision detection disabled
// R16 - active carrier: high while carrier seen
// R17 - low carrier: held low, no detection
// R18 - ability writes advertised only after restart; the code drives adv_word from adv as soon as it is written
// R19 - resolve 100 full, 100 half, 10 full, 10 half
// R20 - restart bit clears itself once started
package plm_pkg;

	// timing
	localparam int CLK_HZ = 100_000_000;
	localparam int BREAK_LINK_MS = 1200;
	localparam int BREAK_LINK_CYC = BREAK_LINK_MS * (CLK_HZ / 1000);
	localparam int BRK_W = 27;

	// register indices, byte address is four times the index
	localparam logic [5:0] IDX_CTRL = 6'h00;
	localparam logic [5:0] IDX_ADV = 6'h04;
	localparam logic [5:0] IDX_LPA = 6'h05;
	localparam logic [5:0] IDX_ANX = 6'h06;
	localparam logic [5:0] IDX_STAT = 6'h08;

	// control register fields
	localparam int CTRL_SPEED_BIT = 13;
	localparam int CTRL_AN_EN_BIT = 12;
	localparam int CTRL_RESTART_BIT = 9;
	localparam int CTRL_DUPLEX_BIT = 8;
	localparam logic [15:0] CTRL_WR_MASK = 16'h3300;
	localparam logic [15:0] CTRL_RST = 16'h3100;

	// ability fields, shared by advertised and partner words
	localparam int ABIL_100FD = 8;
	localparam int ABIL_100HD = 7;
	localparam int ABIL_10FD = 6;
	localparam int ABIL_10HD = 5;
	localparam logic [15:0] ADV_WR_MASK = 16'h01e0;
	localparam logic [15:0] ADV_RST = 16'h01e1;
	localparam logic [15:0] SEL_8023 = 16'h0001;

	// expansion and status fields
	localparam int ANX_LP_AN_BIT = 0;
	localparam int ANX_PD_FAULT_BIT = 4;
	localparam int STAT_LINK_BIT = 0;
	localparam int STAT_SPEED_BIT = 1;
	localparam int STAT_FD_BIT = 2;
	localparam int STAT_HALT_BIT = 3;
	localparam int STAT_STATE_LSB = 4;

	// bus responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		ST_FORCED = 2'b00,
		ST_BREAK = 2'b01,
		ST_NEG = 2'b10,
		ST_LINK = 2'b11
	} plm_state_t;

	// indications from the on-chip receive and transmit datapath
	typedef struct packed {
		logic flp_valid;
		logic [15:0] flp_word;
		logic mlt3_det;
		logic nlp_det;
		logic pd_fault;
		logic sig_det;
		logic tx_act;
		logic rx_act;
	} plm_line_t;

	// resolved mode toward mac and datapath
	typedef struct packed {
		logic link_up;
		logic speed100;
		logic full_duplex;
		logic crs;
		logic col;
		logic halt;
		logic flp_tx_en;
		logic [15:0] adv_word;
	} plm_mode_t;

	typedef struct packed {
		logic [15:0] ctrl;
		logic [15:0] adv;
		logic [15:0] lpa;
		logic lp_an;
		logic pd_fault;
		plm_state_t state;
		logic [BRK_W-1:0] brk_cnt;
		logic speed100;
		logic fd;
		logic link;
		logic crs;
		logic col;
		logic halt;
		logic flp_tx;
	} plm_regs_t;

	typedef struct packed {
		logic aw_got;
		logic w_got;
		logic [7:0] awaddr;
		logic [15:0] wdata;
		logic [1:0] wstrb;
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
	} plm_axi_t;

	typedef struct packed {
		plm_regs_t r;
		plm_axi_t b;
	} plm_st_t;

	localparam plm_st_t ST_RESET = '{
		r: '{ctrl: CTRL_RST, adv: ADV_RST, lpa: 16'h0000, lp_an: 1'b0, pd_fault: 1'b0,
			state: ST_NEG, brk_cnt: '0, speed100: 1'b0, fd: 1'b0, link: 1'b0,
			crs: 1'b0, col: 1'b0, halt: 1'b0, flp_tx: 1'b0},
		b: '0
	};

endpackage : plm_pkg
